// ==== fpa_pkg.sv ====
// constants and types for the flash program memory access block
package fpa_pkg;

  // ****************************************
  // flash command register codes
  // ****************************************
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE_PG = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  localparam logic [7:0] CMD_RD_BYTE = 8'h81;
  localparam logic [7:0] CMD_WR_BYTE = 8'h82;
  localparam logic [7:0] CMD_EXIT_UL = 8'h0f;
  localparam logic [7:0] CMD_ENTER_UL = 8'hf0;
  localparam logic [7:0] VERIFY_OK = 8'h00;
  localparam logic [7:0] VERIFY_BAD = 8'h01;

  // ****************************************
  // parallel programming mode codes
  // ****************************************
  localparam logic [3:0] PP_ERASE_ALL = 4'h0;
  localparam logic [3:0] PP_PROG_CODE = 4'ha;
  localparam logic [3:0] PP_PROG_DATA = 4'h2;
  localparam logic [3:0] PP_READ_CODE = 4'hb;
  localparam logic [3:0] PP_READ_DATA = 4'h3;
  localparam logic [3:0] PP_PROG_SEC = 4'hc;
  localparam logic [3:0] PP_READ_SEC = 4'hd;

  // ****************************************
  // memory map
  // ****************************************
  localparam logic [15:0] HIDDEN_BASE = 16'hf800;
  localparam logic [15:0] TOP_64K = 16'hf800;
  localparam logic [15:0] TOP_32K = 16'h8000;
  localparam logic [15:0] TOP_8K = 16'h2000;
  localparam logic [15:0] BOOT_64K = 16'he000;
  localparam logic [15:0] BOOT_32K = 16'h6000;
  localparam logic [15:0] BOOT_8K = 16'h0000;
  localparam logic [15:0] CODE_PAGE_MASK = 16'hffc0;
  localparam int DF_PAGE_W = 10;
  localparam int DF_BYTE_W = 12;

  // ****************************************
  // security bits and types
  // ****************************************
  localparam int SEC_LOCK = 0;
  localparam int SEC_SECURE = 1;
  localparam int SEC_SSAFE = 2;
  localparam int SEC_W = 3;
  localparam logic [SEC_W-1:0] SEC_NONE = 3'h0;

  typedef enum logic [1:0] {
    FPA_V64K = 2'b00,
    FPA_V32K = 2'b01,
    FPA_V8K = 2'b11
  } fpa_variant_t;

  typedef enum logic {
    ST_INIT = 1'b0,
    ST_RUN = 1'b1
  } fpa_state_t;

endpackage

// ==== fpa_region.sv ====
// address classification of the program flash for one address
module fpa_region
  import fpa_pkg::*;
(
  input wire fpa_pkg::fpa_variant_t variant,
  input wire logic [15:0] addr,
  output logic hidden,
  output logic user_area,
  output logic user_download_mode_ok
);
  import fpa_pkg::*;

  function automatic logic [15:0] user_top(input fpa_variant_t v);
    unique case (v)
      FPA_V32K: user_top = TOP_32K;
      FPA_V8K: user_top = TOP_8K;
      default: user_top = TOP_64K;
    endcase
  endfunction

  function automatic logic [15:0] boot_base(input fpa_variant_t v);
    unique case (v)
      FPA_V32K: boot_base = BOOT_32K;
      FPA_V8K: boot_base = BOOT_8K;
      default: boot_base = BOOT_64K;
    endcase
  endfunction

  // top 2k always belongs to the firmware, whatever the variant
  assign hidden = addr >= HIDDEN_BASE;
  assign user_area = !hidden && (addr < user_top(variant));
  // boot area sits between boot_base and user_top
  assign user_download_mode_ok = addr < boot_base(variant);

endmodule

// ==== fpa_access.sv ====
// flash program memory access, protection and data flash commands
module fpa_access
  import fpa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] mem_variant,
  input wire logic code_fetch_strobe_n,
  output logic serial_dl_mode,
  input wire logic [SEC_W-1:0] sec_nv_in,
  output logic [SEC_W-1:0] sec_nv_out,
  output logic sec_nv_we,
  input wire logic sec_set_we,
  input wire logic [SEC_W-1:0] sec_set_bits,
  input wire logic pp_active,
  input wire logic [7:0] pp_addr_lo,
  input wire logic [7:0] pp_addr_hi,
  input wire logic [7:0] pp_data_in,
  output logic [7:0] pp_data_out,
  output logic pp_data_oe,
  input wire logic pp_we_n,
  input wire logic [3:0] pp_mode,
  input wire logic [15:0] cpu_rd_addr,
  input wire logic cpu_rd_ext,
  output logic [7:0] cpu_rd_data,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_cmd_we,
  input wire logic page_addr_high_we,
  input wire logic page_addr_low_we,
  input wire logic [3:0] page_data_we,
  output logic [7:0] page_addr_high,
  output logic [7:0] page_addr_low,
  output logic [31:0] page_data_regs,
  output logic [7:0] flash_command_reg,
  output logic user_download_mode,
  output logic [15:0] code_rd_addr,
  input wire logic [7:0] code_rd_data,
  output logic code_wr,
  output logic code_erase_pg,
  output logic code_erase_ul,
  output logic code_erase_all,
  output logic [15:0] code_wr_addr,
  output logic [7:0] code_wr_data,
  output logic [DF_PAGE_W-1:0] df_rd_addr,
  input wire logic [31:0] df_rd_data,
  output logic df_wr,
  output logic [3:0] df_wr_be,
  output logic [DF_PAGE_W-1:0] df_wr_addr,
  output logic [31:0] df_wr_data,
  output logic df_erase_pg,
  output logic df_erase_all
);
  import fpa_pkg::*;

  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0] i);
    pick_byte = w[{i, 3'b000} +: 8];
  endfunction

  // ****************************************
  // state
  // ****************************************
  fpa_state_t state_q;
  fpa_variant_t variant_q;
  logic [SEC_W-1:0] sec_q, sec_d;
  logic boot_dl_q, user_download_mode_q, user_download_mode_d, pp_we_q;
  logic [7:0] pa_hi_q, pa_lo_q, cmd_rd_q, cmd_rd_d;
  logic [31:0] pd_q, pd_d;
  logic [7:0] cpu_rd_q, pp_out_q;
  logic code_wr_q, code_erase_pg_q, code_erase_ul_q, code_erase_all_q;
  logic [15:0] code_wr_addr_q, code_wr_addr_d;
  logic [7:0] code_wr_data_q;
  logic df_wr_q, df_erase_pg_q, df_erase_all_q, sec_nv_we_q;
  logic [3:0] df_wr_be_q, df_wr_be_d;
  logic [DF_PAGE_W-1:0] df_wr_addr_q;
  logic [31:0] df_wr_data_q, df_wr_data_d;

  // ****************************************
  // decode
  // ****************************************
  wire run = state_q == ST_RUN;
  wire [15:0] byte_addr = {pa_hi_q, pa_lo_q};
  wire [15:0] pp_addr = {pp_addr_hi, pp_addr_lo};
  wire [DF_PAGE_W-1:0] df_page_sfr = {pa_hi_q[1:0], pa_lo_q};
  wire [DF_BYTE_W-1:0] df_byte_sfr = byte_addr[DF_BYTE_W-1:0];
  wire [DF_BYTE_W-1:0] df_byte_pp = pp_addr[DF_BYTE_W-1:0];
  wire sfr_hidden, sfr_user, sfr_user_download_mode_ok;
  wire pp_hidden, pp_user, pp_user_download_mode_ok;
  wire ul_avail = variant_q != FPA_V8K;
  wire lock = sec_q[SEC_LOCK];
  wire secure = sec_q[SEC_SECURE];

  fpa_region u_reg_sfr (
    .variant(variant_q),
    .addr(byte_addr),
    .hidden(sfr_hidden),
    .user_area(sfr_user),
    .user_download_mode_ok(sfr_user_download_mode_ok)
  );

  fpa_region u_reg_pp (
    .variant(variant_q),
    .addr(pp_addr),
    .hidden(pp_hidden),
    .user_area(pp_user),
    .user_download_mode_ok(pp_user_download_mode_ok)
  );

  // commands are ignored while a programmer owns the arrays
  wire cmd_go = run && sfr_cmd_we && !pp_active;
  wire c_read = cmd_go && sfr_wdata == CMD_READ;
  wire c_write = cmd_go && sfr_wdata == CMD_WRITE;
  wire c_verify = cmd_go && sfr_wdata == CMD_VERIFY;
  wire c_er_pg = cmd_go && sfr_wdata == CMD_ERASE_PG;
  wire c_er_all = cmd_go && sfr_wdata == CMD_ERASE_ALL;
  wire c_rd_byte = cmd_go && sfr_wdata == CMD_RD_BYTE;
  wire c_wr_byte = cmd_go && sfr_wdata == CMD_WR_BYTE;
  wire c_exit = cmd_go && sfr_wdata == CMD_EXIT_UL;
  wire c_enter = cmd_go && sfr_wdata == CMD_ENTER_UL;

  // the download kernel may reach the boot area, user code may not
  wire code_ok = boot_dl_q ? sfr_user : (sfr_user && sfr_user_download_mode_ok);
  wire ul_wr_byte = c_wr_byte && user_download_mode_q && code_ok;
  wire ul_er_pg = c_er_pg && user_download_mode_q && code_ok;
  wire ul_er_all = c_er_all && user_download_mode_q;
  wire kern_erase = ul_er_all && boot_dl_q;
  wire nm_write = c_write && !user_download_mode_q;
  wire nm_wr_byte = c_wr_byte && !user_download_mode_q;
  wire nm_er_pg = c_er_pg && !user_download_mode_q;
  wire nm_er_all = c_er_all && !user_download_mode_q;
  wire nm_verify = c_verify && !user_download_mode_q;

  // write strobe acts on its falling edge
  wire pp_fire = run && pp_active && pp_we_q && !pp_we_n;
  wire pp_erase = pp_fire && pp_mode == PP_ERASE_ALL;
  wire pp_prog_code = pp_fire && pp_mode == PP_PROG_CODE && !lock
                      && !secure && pp_user;
  wire pp_prog_data = pp_fire && pp_mode == PP_PROG_DATA;
  wire pp_prog_sec = pp_fire && pp_mode == PP_PROG_SEC;
  wire pp_rd_mode = pp_mode == PP_READ_CODE || pp_mode == PP_READ_DATA
                    || pp_mode == PP_READ_SEC;

  // ****************************************
  // array addressing
  // ****************************************
  assign code_rd_addr = pp_active ? pp_addr : cpu_rd_addr;
  // byte commands and parallel programming address the data flash by byte, other commands by page
  wire df_use_byte = sfr_cmd_we
                     && (sfr_wdata == CMD_RD_BYTE || sfr_wdata == CMD_WR_BYTE);
  assign df_rd_addr = pp_active ? df_byte_pp[DF_BYTE_W-1:2]
                    : df_use_byte ? df_byte_sfr[DF_BYTE_W-1:2]
                    : df_page_sfr;
  wire [3:0] sfr_be = 4'h1 << df_byte_sfr[1:0];
  wire [3:0] pp_be = 4'h1 << df_byte_pp[1:0];

  // ****************************************
  // next values
  // ****************************************
  always_comb
  begin
    sec_d = sec_q;
    if (sec_set_we && boot_dl_q)
    begin
      sec_d = sec_q | sec_set_bits;
    end
    if (pp_prog_sec)
    begin
      sec_d = sec_q | pp_data_in[SEC_W-1:0];
    end
    if (kern_erase)
    begin
      // serial-safe survives a kernel erase
      sec_d[SEC_LOCK] = 1'b0;
      sec_d[SEC_SECURE] = 1'b0;
    end
    if (pp_erase)
    begin
      sec_d = SEC_NONE;
    end
  end

  always_comb
  begin
    pd_d = pd_q;
    for (int i = 0; i < 4; i++)
    begin
      if (page_data_we[i])
      begin
        pd_d[i*8 +: 8] = sfr_wdata;
      end
    end
    if (c_read && !user_download_mode_q)
    begin
      pd_d = df_rd_data;
    end
    if (c_rd_byte && !user_download_mode_q)
    begin
      pd_d[7:0] = pick_byte(df_rd_data, df_byte_sfr[1:0]);
    end
  end

  always_comb
  begin
    user_download_mode_d = user_download_mode_q;
    if (c_enter && ul_avail)
    begin
      user_download_mode_d = 1'b1;
    end
    if (c_exit)
    begin
      user_download_mode_d = 1'b0;
    end
  end

  // readback shows the last command unless a verify just ran
  assign cmd_rd_d = nm_verify
                    ? ((df_rd_data == pd_q) ? VERIFY_OK : VERIFY_BAD)
                    : cmd_go ? sfr_wdata : cmd_rd_q;
  assign code_wr_addr_d = pp_active ? pp_addr
                        : c_er_pg ? (byte_addr & CODE_PAGE_MASK)
                        : byte_addr;
  assign df_wr_be_d = pp_active ? pp_be : nm_write ? 4'hf : sfr_be;
  assign df_wr_data_d = pp_active ? {4{pp_data_in}}
                      : nm_write ? pd_q : {4{pd_q[7:0]}};

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_INIT;
      variant_q <= FPA_V64K;
      sec_q <= SEC_NONE;
      boot_dl_q <= 1'b0;
      sec_nv_we_q <= 1'b0;
    end
    else if (state_q == ST_INIT)
    begin
      // straps and stored security caught just after release
      state_q <= ST_RUN;
      variant_q <= fpa_variant_t'(mem_variant);
      sec_q <= sec_nv_in;
      boot_dl_q <= !code_fetch_strobe_n
                   && !sec_nv_in[SEC_SSAFE];
    end
    else
    begin
      sec_q <= sec_d;
      sec_nv_we_q <= sec_d != sec_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      user_download_mode_q <= 1'b0;
      pa_hi_q <= 8'h00;
      pa_lo_q <= 8'h00;
      pd_q <= 32'h0000_0000;
      cmd_rd_q <= 8'h00;
      pp_we_q <= 1'b1;
    end
    else
    begin
      user_download_mode_q <= user_download_mode_d;
      pa_hi_q <= page_addr_high_we ? sfr_wdata : pa_hi_q;
      pa_lo_q <= page_addr_low_we ? sfr_wdata : pa_lo_q;
      pd_q <= pd_d;
      cmd_rd_q <= cmd_rd_d;
      pp_we_q <= pp_we_n;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      code_wr_q <= 1'b0;
      code_erase_pg_q <= 1'b0;
      code_erase_ul_q <= 1'b0;
      code_erase_all_q <= 1'b0;
      code_wr_addr_q <= 16'h0000;
      code_wr_data_q <= 8'h00;
    end
    else
    begin
      code_wr_q <= ul_wr_byte || pp_prog_code;
      code_erase_pg_q <= ul_er_pg;
      code_erase_ul_q <= ul_er_all && !boot_dl_q;
      code_erase_all_q <= pp_erase || kern_erase;
      code_wr_addr_q <= code_wr_addr_d;
      code_wr_data_q <= pp_active ? pp_data_in : pd_q[7:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      df_wr_q <= 1'b0;
      df_erase_pg_q <= 1'b0;
      df_erase_all_q <= 1'b0;
      df_wr_be_q <= 4'h0;
      df_wr_addr_q <= '0;
      df_wr_data_q <= 32'h0000_0000;
    end
    else
    begin
      df_wr_q <= nm_write || nm_wr_byte || pp_prog_data;
      df_erase_pg_q <= nm_er_pg;
      df_erase_all_q <= nm_er_all || pp_erase || kern_erase;
      df_wr_be_q <= df_wr_be_d;
      df_wr_addr_q <= df_rd_addr;
      df_wr_data_q <= df_wr_data_d;
    end
  end

  // ****************************************
  // read data paths
  // ****************************************
  wire sfr_hidden_cpu = cpu_rd_addr >= HIDDEN_BASE;
  wire cpu_blank = (sfr_hidden_cpu && !boot_dl_q)
                   || (cpu_rd_ext && secure);
  wire [7:0] pp_rd_val = pp_mode == PP_READ_SEC ? {5'h00, sec_q}
                       : pp_mode == PP_READ_DATA
                         ? pick_byte(df_rd_data, df_byte_pp[1:0])
                       : pp_mode == PP_READ_CODE && !secure && !pp_hidden
                         ? code_rd_data : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cpu_rd_q <= 8'h00;
      pp_out_q <= 8'h00;
    end
    else
    begin
      cpu_rd_q <= cpu_blank ? 8'h00 : code_rd_data;
      pp_out_q <= pp_rd_val;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign serial_dl_mode = boot_dl_q;
  assign sec_nv_out = sec_q;
  assign sec_nv_we = sec_nv_we_q;
  assign pp_data_out = pp_out_q;
  assign pp_data_oe = run && pp_active && pp_we_n && pp_rd_mode;
  assign cpu_rd_data = cpu_rd_q;
  assign page_addr_high = pa_hi_q;
  assign page_addr_low = pa_lo_q;
  assign page_data_regs = pd_q;
  assign flash_command_reg = cmd_rd_q;
  assign user_download_mode = user_download_mode_q;
  assign code_wr = code_wr_q;
  assign code_erase_pg = code_erase_pg_q;
  assign code_erase_ul = code_erase_ul_q;
  assign code_erase_all = code_erase_all_q;
  assign code_wr_addr = code_wr_addr_q;
  assign code_wr_data = code_wr_data_q;
  assign df_wr = df_wr_q;
  assign df_wr_be = df_wr_be_q;
  assign df_wr_addr = df_wr_addr_q;
  assign df_wr_data = df_wr_data_q;
  assign df_erase_pg = df_erase_pg_q;
  assign df_erase_all = df_erase_all_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_hidden_zero: assert property (
    run && cpu_rd_addr >= HIDDEN_BASE && !boot_dl_q |=> cpu_rd_data == 8'h00)
    else $error("hidden region read not zero");
  chk_serial_entry: assert property (
    state_q == ST_INIT && !code_fetch_strobe_n && !sec_nv_in[SEC_SSAFE]
    |=> serial_dl_mode [*2])
    else $error("serial download not entered");
  chk_ssafe_normal: assert property (
    state_q == ST_INIT && sec_nv_in[SEC_SSAFE] |=> !serial_dl_mode)
    else $error("serial-safe did not block download");
  chk_normal_ro: assert property (
    !user_download_mode_q && !pp_active |=> !code_wr && !code_erase_pg && !code_erase_ul)
    else $error("program flash written in normal mode");
  chk_boot_guard: assert property (
    code_wr && !$past(pp_active) && !$past(boot_dl_q)
    |-> $past(sfr_user_download_mode_ok))
    else $error("boot area written by user code");
  chk_no_user_download_mode_8k: assert property (
    run && variant_q == FPA_V8K |-> !user_download_mode)
    else $error("user download on small variant");
  chk_lock_refuse: assert property (
    pp_fire && pp_mode == PP_PROG_CODE && (lock || secure) |=> !code_wr)
    else $error("locked code programmed");
  chk_secure_read: assert property (
    run && pp_active && pp_mode == PP_READ_CODE && secure
    |=> pp_data_out == 8'h00)
    else $error("secure code read leaked");
  chk_erase_clears: assert property (
    pp_erase |=> sec_nv_out == SEC_NONE && code_erase_all && df_erase_all)
    else $error("parallel erase incomplete");
  chk_kern_ssafe: assert property (
    kern_erase && sec_q[SEC_SSAFE] && !pp_erase
    |=> sec_nv_out[SEC_SSAFE] && !sec_nv_out[SEC_LOCK])
    else $error("kernel erase changed serial-safe");
  chk_verify_code: assert property (
    nm_verify |=> (flash_command_reg == VERIFY_OK)
                  == ($past(df_rd_data) == $past(pd_q)))
    else $error("verify result wrong");

  cov_user_download_mode_write: cover property (c_enter ##[1:20] ul_wr_byte);
  cov_pp_prog: cover property (pp_prog_code ##1 code_wr);
  cov_verify_bad: cover property (nm_verify ##1 flash_command_reg != 8'h00);

endmodule

// ==== fpa_flash_model.sv ====
// behavioural program flash, data flash and security cell
module fpa_flash_model
  import fpa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [1:0] mem_variant,
  input wire logic [15:0] code_rd_addr,
  output logic [7:0] code_rd_data,
  input wire logic code_wr,
  input wire logic code_erase_pg,
  input wire logic code_erase_ul,
  input wire logic code_erase_all,
  input wire logic [15:0] code_wr_addr,
  input wire logic [7:0] code_wr_data,
  input wire logic [DF_PAGE_W-1:0] df_rd_addr,
  output logic [31:0] df_rd_data,
  input wire logic df_wr,
  input wire logic [3:0] df_wr_be,
  input wire logic [DF_PAGE_W-1:0] df_wr_addr,
  input wire logic [31:0] df_wr_data,
  input wire logic df_erase_pg,
  input wire logic df_erase_all,
  input wire logic [SEC_W-1:0] sec_nv_out,
  input wire logic sec_nv_we,
  output logic [SEC_W-1:0] sec_nv_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] code_mem [0:65535];
  logic [31:0] df_mem [0:1023];
  logic [SEC_W-1:0] nv_q;
  logic [15:0] ul_top;
  assign code_rd_data = code_mem[code_rd_addr];
  assign df_rd_data = df_mem[df_rd_addr];
  assign sec_nv_in = nv_q;
  assign ul_top = (mem_variant == 2'b01) ? BOOT_32K : BOOT_64K;
  // ****************************************
  // array contents and updates
  // ****************************************
  initial
  begin
    // nonzero firmware pattern so hidden reads prove the masking
    for (int i = 0; i < 65536; i++)
      code_mem[i] = 8'(i) ^ 8'h5a;
    for (int i = 0; i < 1024; i++)
      df_mem[i] = 32'hffffffff;
    nv_q = '0;
  end
  // programming only clears bits, as the real cells do
  always @(posedge clk_sys)
  begin
    if (code_wr)
      code_mem[code_wr_addr] <= code_mem[code_wr_addr] & code_wr_data;
    // walk the whole array only when an erase asks for it
    if (code_erase_pg || code_erase_ul || code_erase_all)
    begin
      for (int i = 0; i < 65536; i++)
      begin
        if ((code_erase_pg && i[15:6] == code_wr_addr[15:6]) ||
            (code_erase_ul && 16'(i) < ul_top) ||
            (code_erase_all && 16'(i) < HIDDEN_BASE))
          code_mem[i] <= 8'hff;
      end
    end
    for (int b = 0; b < 4; b++)
    begin
      if (df_wr && df_wr_be[b])
        df_mem[df_wr_addr][8*b+:8] <= df_mem[df_wr_addr][8*b+:8] &
                                      df_wr_data[8*b+:8];
    end
    if (df_erase_pg)
      df_mem[df_wr_addr] <= 32'hffffffff;
    if (df_erase_all)
    begin
      for (int i = 0; i < 1024; i++)
        df_mem[i] <= 32'hffffffff;
    end
    if (sec_nv_we)
      nv_q <= sec_nv_out;
  end
endmodule

// ==== fpa_access_tb.sv ====
// self-checking bench for the flash program memory access block
module fpa_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fpa_pkg::*;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
  logic clk_sys, rst, code_fetch_strobe_n, sec_set_we, pp_active;
  logic pp_we_n, cpu_rd_ext, sfr_cmd_we, page_addr_high_we;
  logic page_addr_low_we, serial_dl_mode, sec_nv_we, pp_data_oe;
  logic user_download_mode, code_wr, code_erase_pg, code_erase_ul;
  logic code_erase_all, df_wr, df_erase_pg, df_erase_all;
  logic [1:0] mem_variant;
  logic [SEC_W-1:0] sec_nv_in, sec_nv_out, sec_set_bits;
  logic [7:0] pp_addr_lo, pp_addr_hi, pp_data_in, pp_data_out;
  logic [7:0] sfr_wdata, cpu_rd_data, page_addr_high, page_addr_low;
  logic [7:0] flash_command_reg, code_rd_data, code_wr_data;
  logic [3:0] pp_mode, page_data_we, df_wr_be;
  logic [15:0] cpu_rd_addr, code_rd_addr, code_wr_addr;
  logic [31:0] page_data_regs, df_rd_data, df_wr_data;
  logic [DF_PAGE_W-1:0] df_rd_addr, df_wr_addr;
  int mismatches = 0;
  int compares = 0;
  fpa_access uut (.clk_sys, .rst, .mem_variant, .code_fetch_strobe_n,
    .serial_dl_mode, .sec_nv_in, .sec_nv_out, .sec_nv_we, .sec_set_we,
    .sec_set_bits, .pp_active, .pp_addr_lo, .pp_addr_hi, .pp_data_in,
    .pp_data_out, .pp_data_oe, .pp_we_n, .pp_mode, .cpu_rd_addr,
    .cpu_rd_ext, .cpu_rd_data, .sfr_wdata, .sfr_cmd_we,
    .page_addr_high_we, .page_addr_low_we, .page_data_we,
    .page_addr_high, .page_addr_low, .page_data_regs, .flash_command_reg,
    .user_download_mode, .code_rd_addr, .code_rd_data, .code_wr,
    .code_erase_pg, .code_erase_ul, .code_erase_all, .code_wr_addr,
    .code_wr_data, .df_rd_addr, .df_rd_data, .df_wr, .df_wr_be,
    .df_wr_addr, .df_wr_data, .df_erase_pg, .df_erase_all);
  fpa_flash_model fm (.clk_sys, .mem_variant, .code_rd_addr,
    .code_rd_data, .code_wr, .code_erase_pg, .code_erase_ul,
    .code_erase_all, .code_wr_addr, .code_wr_data, .df_rd_addr,
    .df_rd_data, .df_wr, .df_wr_be, .df_wr_addr, .df_wr_data,
    .df_erase_pg, .df_erase_all, .sec_nv_out, .sec_nv_we, .sec_nv_in);
  // ****************************************
  // clock, access tasks and closing
  // ****************************************
  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  task tick;
    @(posedge clk_sys);
    #5;
  endtask
  task do_reset(input logic [1:0] v, input logic s);
    mem_variant = v;
    code_fetch_strobe_n = s;
    rst = 1;
    repeat (5) tick;
    rst = 0;
    repeat (2) tick;
  endtask
  // s: 0 command, 1 high addr, 2 low addr, 3..6 page data bytes
  task sw(input int s, input logic [7:0] d);
    logic [6:0] v;
    v = 7'h1 << s;
    sfr_wdata = d;
    {page_data_we, page_addr_low_we, page_addr_high_we, sfr_cmd_we} = v;
    tick;
    {page_data_we, page_addr_low_we, page_addr_high_we, sfr_cmd_we} = '0;
    repeat (2) tick;
  endtask
  task pa(input logic [15:0] a);
    sw(1, a[15:8]);
    sw(2, a[7:0]);
  endtask
  // strobe held low one cycle, then high long enough to settle
  task pp(input logic [3:0] m, input logic [15:0] a, input logic [7:0] d);
    pp_mode = m;
    {pp_addr_hi, pp_addr_lo} = a;
    pp_data_in = d;
    pp_we_n = 0;
    tick;
    pp_we_n = 1;
    repeat (3) tick;
  endtask
  task cr(input logic [15:0] a, input logic x);
    cpu_rd_addr = a;
    cpu_rd_ext = x;
    repeat (2) tick;
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test;
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    {rst, mem_variant, code_fetch_strobe_n, sec_set_we, sec_set_bits} = '1;
    {sec_set_we, sec_set_bits, pp_active, cpu_rd_ext, sfr_cmd_we} = '0;
    {pp_addr_lo, pp_addr_hi, pp_data_in, sfr_wdata, cpu_rd_addr} = '0;
    {page_addr_high_we, page_addr_low_we, page_data_we} = '0;
    pp_we_n = 1;
    pp_mode = 4'hf;
    do_reset(2'b00, 1);
    `CHK("dl", 1'b0, serial_dl_mode)
    cr(16'hf800, 0);
    `CHK("hidden", 8'h00, cpu_rd_data)
    cr(16'h0010, 0);
    `CHK("user", 8'h4a, cpu_rd_data)
    $display("test map done");
    pa(16'h0003);
    `CHK("pa", 16'h0003, {page_addr_high, page_addr_low})
    for (int i = 0; i < 4; i++)
      sw(3 + i, 8'(8'h11 * (i + 1)));
    sw(0, CMD_WRITE);
    `CHK("df", 32'h44332211, fm.df_mem[3])
    sw(0, CMD_VERIFY);
    `CHK("vfy", VERIFY_OK, flash_command_reg)
    sw(3, 8'h99);
    sw(0, CMD_VERIFY);
    `CHK("vfy", VERIFY_BAD, flash_command_reg)
    sw(0, CMD_READ);
    `CHK("pdata", 32'h44332211, page_data_regs)
    pa(16'h000d);
    sw(0, CMD_RD_BYTE);
    `CHK("rdbyte", 8'h22, page_data_regs[7:0])
    pa(16'h0003);
    sw(0, CMD_ERASE_PG);
    `CHK("df", 32'hffffffff, fm.df_mem[3])
    $display("test data flash done");
    sw(0, CMD_ENTER_UL);
    `CHK("ul", 1'b1, user_download_mode)
    pa(16'h0100);
    sw(0, CMD_ERASE_PG);
    sw(3, 8'ha5);
    sw(0, CMD_WR_BYTE);
    `CHK("code", 8'ha5, fm.code_mem[16'h0100])
    pa(16'he000);
    sw(0, CMD_ERASE_PG);
    sw(0, CMD_WR_BYTE);
    `CHK("boot", 8'h5a, fm.code_mem[16'he000])
    `CHK("boot", 8'h5b, fm.code_mem[16'he001])
    pa(16'hf800);
    sw(0, CMD_WR_BYTE);
    `CHK("hid", 8'h5a, fm.code_mem[16'hf800])
    sw(0, CMD_EXIT_UL);
    `CHK("ul", 1'b0, user_download_mode)
    pa(16'h0100);
    sw(3, 8'h77);
    sw(0, CMD_WR_BYTE);
    `CHK("code", 8'ha5, fm.code_mem[16'h0100])
    `CHK("dfbyte", 32'hffffff77, fm.df_mem[10'h040])
    $display("test user download done");
    pp_active = 1;
    tick;
    pp(PP_READ_CODE, 16'h0100, 8'h00);
    `CHK("pprd", 8'ha5, pp_data_out)
    `CHK("oe", 1'b1, pp_data_oe)
    pp(PP_PROG_CODE, 16'h0110, 8'h3c);
    `CHK("ppcode", 8'h3c, fm.code_mem[16'h0110])
    pp(PP_PROG_DATA, 16'h0005, 8'h66);
    `CHK("ppdata", 8'h66, fm.df_mem[1][15:8])
    pp(PP_READ_DATA, 16'h0005, 8'h00);
    `CHK("pprd", 8'h66, pp_data_out)
    pp(PP_PROG_SEC, 16'h0000, 8'h01);
    `CHK("sec", 3'b001, sec_nv_out)
    `CHK("nv", 3'b001, fm.nv_q)
    pp(PP_PROG_CODE, 16'h0300, 8'h00);
    `CHK("lock", 8'h5a, fm.code_mem[16'h0300])
    pp(PP_READ_CODE, 16'h0110, 8'h00);
    `CHK("lock", 8'h3c, pp_data_out)
    pp_active = 0;
    cr(16'h0010, 1);
    `CHK("lock", 8'h4a, cpu_rd_data)
    pp_active = 1;
    pp(PP_PROG_SEC, 16'h0000, 8'h02);
    pp(PP_READ_CODE, 16'h0110, 8'h00);
    `CHK("sec", 8'h00, pp_data_out)
    pp(4'h7, 16'h0000, 8'h04);
    `CHK("sec", 3'b011, sec_nv_out)
    pp_active = 0;
    cr(16'h0010, 1);
    `CHK("sec", 8'h00, cpu_rd_data)
    cr(16'h0010, 0);
    pp_active = 1;
    pp(PP_ERASE_ALL, 16'h0000, 8'h00);
    `CHK("sec", 3'b000, sec_nv_out)
    `CHK("erase", 8'hff, fm.code_mem[16'h0110])
    `CHK("erase", 32'hffffffff, fm.df_mem[1])
    $display("test parallel done");
    pp(PP_PROG_SEC, 16'h0000, 8'h04);
    pp_active = 0;
    do_reset(2'b00, 0);
    `CHK("dl", 1'b0, serial_dl_mode)
    pp_active = 1;
    pp(PP_ERASE_ALL, 16'h0000, 8'h00);
    `CHK("nv", 3'b000, fm.nv_q)
    pp_active = 0;
    do_reset(2'b00, 0);
    `CHK("dl", 1'b1, serial_dl_mode)
    sec_set_bits = 3'b111;
    sec_set_we = 1;
    tick;
    sec_set_we = 0;
    repeat (2) tick;
    `CHK("sec", 3'b111, sec_nv_out)
    sw(0, CMD_ENTER_UL);
    sw(0, CMD_ERASE_ALL);
    `CHK("sec", 3'b100, sec_nv_out)
    $display("test serial download done");
    do_reset(2'b01, 1);
    sw(0, CMD_ENTER_UL);
    pa(16'h6000);
    sw(3, 8'hc3);
    sw(0, CMD_WR_BYTE);
    `CHK("b32", 8'hff, fm.code_mem[16'h6000])
    pa(16'h5fff);
    sw(0, CMD_WR_BYTE);
    `CHK("b32", 8'hc3, fm.code_mem[16'h5fff])
    sw(0, CMD_ERASE_ALL);
    `CHK("ulerase", 8'hff, fm.code_mem[16'h5fff])
    `CHK("ulerase", 3'b100, sec_nv_out)
    do_reset(2'b11, 1);
    sw(0, CMD_ENTER_UL);
    `CHK("ul8k", 1'b0, user_download_mode)
    $display("test variants done");
    stop_test;
  end
endmodule
